// ===== chm_pkg.sv
// chm_pkg: register map, field positions, timing counts and shared types
// for the clock health monitor.
// assumes a 100 MHz core clock; all users reference items as chm_pkg::name.
package chm_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_FAULT    = 8'h04;
  localparam logic [7:0] ADDR_WARN     = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_BIST     = 8'h14;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int BIT_CORE  = 0;
  localparam int BIT_SRC   = 1;
  localparam int BIT_SYNC  = 2;
  localparam int BIT_REG1  = 3;
  localparam int BIT_REG2  = 4;
  localparam int BIT_BOOST = 6;
  localparam int CTRL_SRC_SEL = 7;
  localparam logic [7:0] CTRL_RST  = 8'h5B;
  localparam logic [7:0] CTRL_MASK = 8'hDF;
  localparam logic [7:0] FAULT_MASK = 8'h5F;
  localparam logic [7:0] WARN_MASK = 8'h5E;
  localparam int IRQ_WARN      = 0;
  localparam int IRQ_ERR       = 1;
  localparam int IRQ_PU_TO     = 2;
  localparam int IRQ_BIST_DONE = 3;
  localparam int IRQ_BIST_FAIL = 4;
  localparam int IRQ_W         = 5;
  localparam int BIST_START    = 0;
  localparam int BIST_BUSY     = 1;
  localparam int BIST_FAILED   = 2;
  localparam int BIST_PU_TO    = 3;

  // monitor index to status bit: sync, core, reg1, reg2, boost, source
  localparam int NUM_MON  = 6;
  localparam int MON_CORE = 1;
  localparam int MON_BIT [0:5] = '{2, 0, 3, 4, 6, 1};

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ         = 100000;
  localparam int SYSTEM_CORE_CLOCK_KHZ      = 8000;
  localparam int DETECT_MAX_SYSC = 143;
  localparam int DETECT_MAX_CYC  = DETECT_MAX_SYSC * CLK_KHZ / SYSTEM_CORE_CLOCK_KHZ;
  localparam int MON_WIN_CYC     = DETECT_MAX_CYC / 2 - 4;
  localparam int PU_TO_US        = 1000;
  localparam int PU_TO_CYC       = PU_TO_US * (CLK_KHZ / 1000);
  localparam int BIST_PULSE_CYC  = 8;
  localparam int BIST_GAP_CYC    = 8;
  localparam int BIST_PULSES     = 2;

  // edge counts per window, and core cycles per reference period
  localparam int EDGE_LO_ERR  = 14;
  localparam int EDGE_LO_WARN = 17;
  localparam int EDGE_HI_WARN = 23;
  localparam int EDGE_HI_ERR  = 26;
  localparam int REF_LO_ERR   = 38;
  localparam int REF_LO_WARN  = 41;
  localparam int REF_HI_WARN  = 49;
  localparam int REF_HI_ERR   = 52;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BS_IDLE  = 2'b00,
    BS_PULSE = 2'b01,
    BS_GAP   = 2'b10,
    BS_DONE  = 2'b11
  } chm_bist_e;

  typedef struct packed {
    logic [7:0] warn;
    logic [7:0] err;
  } chm_flags_s;

endpackage : chm_pkg

// ===== chm_freq_mon.sv
// chm_freq_mon: one digital frequency monitor with warning and error bands.
// assumes pin is asynchronous to clk; warn/err are live levels, not sticky.
`timescale 1ns/1ps
module chm_freq_mon #(
  parameter bit MODE    = 1'b0,  // 0: pin edges per window, 1: clk cycles per pin period
  parameter int WIN     = chm_pkg::MON_WIN_CYC,
  parameter int LO_ERR  = chm_pkg::EDGE_LO_ERR,
  parameter int LO_WARN = chm_pkg::EDGE_LO_WARN,
  parameter int HI_WARN = chm_pkg::EDGE_HI_WARN,
  parameter int HI_ERR  = chm_pkg::EDGE_HI_ERR
) (
  input  wire logic clk,        // core clock
  input  wire logic nrst,       // sync reset, active low
  input  wire logic ce,         // clock enable
  input  wire logic en,         // monitor enabled
  input  wire logic force_flt,  // self-test pulse
  input  wire logic pin,        // monitored or reference clock pin
  output logic      warn,       // frequency outside warning band
  output logic      err         // frequency outside error band
);

  localparam int CW = 12;

  logic          s1_reg, s2_reg, s3_reg, frc_d_reg, arm_reg;
  logic [CW-1:0] win_reg, cnt_reg;
  logic          warn_next, err_next;

  // a test pulse restarts the measurement so forced flags never outlive it
  wire           restart  = !en | force_flt;
  wire           frc_end  = frc_d_reg & ~force_flt;
  wire           edge_det = s2_reg & ~s3_reg;
  wire           win_end  = MODE ? edge_det : (win_reg == CW'(WIN - 1));
  // a period count that began mid-period is too short: judge it only once armed
  wire           lo_ok    = !MODE | arm_reg;
  wire           tick     = MODE ? 1'b1 : edge_det;
  wire [CW-1:0]  cnt_now  = (cnt_reg == '1) ? cnt_reg : cnt_reg + CW'(tick);
  // a count above the band shows mid-window, below it only when the window closes
  wire           hi_err   = cnt_now > CW'(HI_ERR);
  wire           hi_warn  = cnt_now > CW'(HI_WARN);
  wire           lo_err   = win_end & lo_ok & (cnt_now < CW'(LO_ERR));
  wire           lo_warn  = win_end & lo_ok & (cnt_now < CW'(LO_WARN));

  // warning band lies inside the error band, so warn never trails err
  assign err_next  = !en ? 1'b0 : force_flt ? 1'b1 :
                     (hi_err | lo_err) ? 1'b1 : (win_end | frc_end) ? 1'b0 : err;
  assign warn_next = !en ? 1'b0 : force_flt ? 1'b1 :
                     (hi_warn | lo_warn) ? 1'b1 : (win_end | frc_end) ? 1'b0 : warn;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      {s1_reg, s2_reg, s3_reg} <= 3'h0;
      frc_d_reg <= 1'b0;
      arm_reg <= 1'b0;
      win_reg <= '0;
      cnt_reg <= '0;
      warn    <= 1'b0;
      err     <= 1'b0;
    end else if (ce) begin
      {s3_reg, s2_reg, s1_reg} <= {s2_reg, s1_reg, pin};
      win_reg <= (restart || win_end) ? '0 : win_reg + CW'(1);
      cnt_reg <= (restart || win_end) ? '0 : cnt_now;
      arm_reg <= !restart & (arm_reg | win_end);
      frc_d_reg <= force_flt;
      warn    <= warn_next;
      err     <= err_next;
    end
  end

  a_warn_with_err : assert property (@(posedge clk) disable iff (!nrst)
    err |-> warn) else $error("error flag without warning flag");

  a_off_when_dis : assert property (@(posedge clk) disable iff (!nrst)
    $past(ce && !en) |-> !err && !warn) else $error("disabled monitor flags");

endmodule : chm_freq_mon

// ===== chm_clock_health_monitor.sv
// chm_clock_health_monitor: clock supervision, flags, self-test and APB registers.
// assumes APB master on clk; device sequencer signals are on clk; clock pins
// and the analog supervisor lines are asynchronous and synchronised here.
//
// What this block does
// - start-up timeout without valid core clock requests off and latches both faults.
// - analog supervisor checks core clock before trim load and cannot be disabled.
// - digital monitors run only after trim download succeeded after power-on reset.
// - six monitors; five against core clock, core clock against selected reference.
// - sync, core, source errors at bits 2, 0, 1; core has no warning.
// - regulator one, two and boost clock flags at bits 3, 4, 6.
// - core clock reference is PLL clock when select is 0, modulated when 1.
// - core clock error sets flags but causes no fault reaction.
// - monitors flag clocks too fast or too slow continuously while enabled.
// - a warning flag is raised no later than the matching error.
// - out-of-range clock detected within 143 cycles of an 8 MHz clock.
// - after reset all monitors enabled except the sync input monitor.
// - self-test runs at every power-up and during the reset extension.
// - self-test gives two pulses per comparator, bypassing status bits.
// - every analog and digital clock monitor is exercised by self-test.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
module chm_clock_health_monitor #(
  parameter int PU_TO_CYC = chm_pkg::PU_TO_CYC  // start-up timeout in clk cycles
) (
  input  wire logic        clk,              // 100 MHz core clock
  input  wire logic        nrst,             // sync reset, active low
  input  wire logic        ce,               // clock enable, freezes state
  input  wire logic [7:0]  paddr,            // APB address
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB enable
  input  wire logic        pwrite,           // APB write
  input  wire logic [31:0] pwdata,           // APB write data
  output logic      [31:0] prdata,           // APB read data
  output logic             pready,           // APB ready
  output logic             pslverr,          // APB error, unmapped address
  input  wire logic        sync_in_clk,      // external sync clock pin
  input  wire logic        pll_clk,          // PLL clock
  input  wire logic        mod_clk,          // modulated clock
  input  wire logic        reg1_clk,         // first regulator switching clock
  input  wire logic        reg2_clk,         // second regulator switching clock
  input  wire logic        boost_clk,        // boost switching clock
  input  wire logic        por_released,     // core out of power-on reset
  input  wire logic        trim_done,        // trim download finished
  input  wire logic        trim_err,         // trim download failed
  input  wire logic        pwrup_active,     // power-up, supplies not yet on
  input  wire logic        reset_ext_active, // reset output extension running
  input  wire logic        op_state_active,  // diagnostic, active or safe state
  input  wire logic        analog_clk_ok,    // analog supervisor: clock valid
  input  wire logic        analog_resp,      // analog supervisor test response
  output logic             off_request,      // return to off state
  output logic             clk_fault_react,  // fault reaction request
  output logic             analog_test,      // test pulse to analog supervisor
  output logic             bist_busy,        // self-test running
  output logic             irq               // level interrupt
);

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  logic [7:0]                ctrl_reg, fault_reg, warn_reg, mask_reg;
  logic [chm_pkg::IRQ_W-1:0] istat_reg;
  logic [7:0]                fault_next, warn_next, set_err, set_warn;
  logic [chm_pkg::IRQ_W-1:0] istat_next, ev;
  logic                      trim_ok_reg, pu_to_reg;
  logic [31:0]               pu_cnt_reg;
  logic                      ak1_reg, ak2_reg, ar1_reg, ar2_reg;
  logic                      pwrup_d_reg, rext_d_reg;
  chm_pkg::chm_bist_e        st_reg, st_next;
  logic [3:0]                st_cnt_reg;
  logic [1:0]                pulse_reg;
  logic                      run_fail_reg;
  logic                      tst_reg;
  chm_pkg::chm_flags_s       raw;
  logic [chm_pkg::NUM_MON-1:0] mon_err, mon_warn, mon_en;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire setup     = psel & ~penable;
  wire acc       = psel & penable & pready;
  wire wr        = acc & pwrite;
  wire hit_ctrl  = paddr == chm_pkg::ADDR_CTRL;
  wire hit_fault = paddr == chm_pkg::ADDR_FAULT;
  wire hit_warn  = paddr == chm_pkg::ADDR_WARN;
  wire hit_istat = paddr == chm_pkg::ADDR_IRQ_STAT;
  wire hit_mask  = paddr == chm_pkg::ADDR_IRQ_MASK;
  wire hit_bist  = paddr == chm_pkg::ADDR_BIST;
  wire hit_any   = hit_ctrl | hit_fault | hit_warn | hit_istat | hit_mask | hit_bist;

  wire [7:0] clr_fault = (wr & hit_fault) ? pwdata[7:0] : 8'h00;
  wire [7:0] clr_warn  = (wr & hit_warn) ? pwdata[7:0] : 8'h00;
  wire [chm_pkg::IRQ_W-1:0] clr_istat =
    (wr & hit_istat) ? pwdata[chm_pkg::IRQ_W-1:0] : '0;

  wire [7:0] bist_rd = {4'h0, pu_to_reg, run_fail_reg, bist_busy, 1'b0};
  wire [31:0] rd_mux =
    hit_ctrl  ? {24'h0, ctrl_reg} :
    hit_fault ? {24'h0, fault_reg} :
    hit_warn  ? {24'h0, warn_reg} :
    hit_istat ? {27'h0, istat_reg} :
    hit_mask  ? {27'h0, mask_reg[chm_pkg::IRQ_W-1:0]} :
    hit_bist  ? {24'h0, bist_rd} : 32'h0;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (ce) begin
      // zero wait states: ready rises in the cycle after setup
      pready  <= setup;
      pslverr <= setup & ~hit_any;
      prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_reg <= chm_pkg::CTRL_RST;
      mask_reg <= 8'h00;
    end else if (ce) begin
      if (wr & hit_ctrl)
        ctrl_reg <= pwdata[7:0] & chm_pkg::CTRL_MASK;
      if (wr & hit_mask)
        mask_reg <= {3'h0, pwdata[chm_pkg::IRQ_W-1:0]};
    end
  end

  // ---------------------------------------------------------------
  // analog supervisor and start-up timeout
  // ---------------------------------------------------------------
  // the timer has no enable bit: it cannot be switched off by software
  wire pu_hit = pwrup_active & ~ak2_reg & ~pu_to_reg &
                (pu_cnt_reg == 32'(PU_TO_CYC - 1));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      {ak1_reg, ak2_reg, ar1_reg, ar2_reg} <= 4'h0;
      pu_cnt_reg  <= 32'h0;
      pu_to_reg   <= 1'b0;
      off_request <= 1'b0;
      trim_ok_reg <= 1'b0;
    end else if (ce) begin
      {ak2_reg, ak1_reg} <= {ak1_reg, analog_clk_ok};
      {ar2_reg, ar1_reg} <= {ar1_reg, analog_resp};
      pu_cnt_reg <= (pwrup_active & ~ak2_reg & ~pu_to_reg) ?
                    pu_cnt_reg + 32'h1 : 32'h0;
      pu_to_reg   <= pu_to_reg | pu_hit;
      off_request <= pwrup_active & (off_request | pu_hit);
      trim_ok_reg <= por_released & (trim_ok_reg | (trim_done & ~trim_err));
    end
  end

  // ---------------------------------------------------------------
  // digital monitors
  // ---------------------------------------------------------------
  // the reference mux sits on raw pins; a glitch at a switch is one bad window
  wire src_clk = ctrl_reg[chm_pkg::CTRL_SRC_SEL] ? mod_clk : pll_clk;
  wire [chm_pkg::NUM_MON-1:0] mon_pin =
    {src_clk, boost_clk, reg2_clk, reg1_clk, src_clk, sync_in_clk};

  for (genvar g = 0; g < chm_pkg::NUM_MON; g++) begin : g_mon
    localparam bit IS_REF = (g == chm_pkg::MON_CORE);
    assign mon_en[g] = trim_ok_reg & ctrl_reg[chm_pkg::MON_BIT[g]];
    chm_freq_mon #(
      .MODE    (IS_REF),
      .WIN     (chm_pkg::MON_WIN_CYC),
      .LO_ERR  (IS_REF ? chm_pkg::REF_LO_ERR  : chm_pkg::EDGE_LO_ERR),
      .LO_WARN (IS_REF ? chm_pkg::REF_LO_WARN : chm_pkg::EDGE_LO_WARN),
      .HI_WARN (IS_REF ? chm_pkg::REF_HI_WARN : chm_pkg::EDGE_HI_WARN),
      .HI_ERR  (IS_REF ? chm_pkg::REF_HI_ERR  : chm_pkg::EDGE_HI_ERR)
    ) u_mon (
      .clk       (clk),
      .nrst      (nrst),
      .ce        (ce),
      .en        (mon_en[g] | tst_reg),
      .force_flt (tst_reg),
      .pin       (mon_pin[g]),
      .warn      (mon_warn[g]),
      .err       (mon_err[g])
    );
  end

  assign raw.err  = {1'b0, mon_err[4], 1'b0, mon_err[3], mon_err[2],
                     mon_err[0], mon_err[5], mon_err[1]};
  assign raw.warn = {1'b0, mon_warn[4], 1'b0, mon_warn[3], mon_warn[2],
                     mon_warn[0], mon_warn[5], 1'b0};

  // ---------------------------------------------------------------
  // sticky flags, fault reaction and interrupt
  // ---------------------------------------------------------------
  // self-test pulses never reach the flags; a new event beats a clear
  assign set_err  = (bist_busy ? 8'h00 : raw.err) | {7'h0, pu_hit};
  assign set_warn = bist_busy ? 8'h00 : raw.warn & chm_pkg::WARN_MASK;
  assign fault_next = (fault_reg & ~clr_fault) | set_err;
  assign warn_next  = (warn_reg & ~clr_warn) | set_warn;
  assign ev[chm_pkg::IRQ_WARN]      = |(set_warn & ~warn_reg);
  assign ev[chm_pkg::IRQ_ERR]       = |(set_err & ~fault_reg);
  assign ev[chm_pkg::IRQ_PU_TO]     = pu_hit;
  assign ev[chm_pkg::IRQ_BIST_DONE] = st_reg == chm_pkg::BS_DONE;
  assign ev[chm_pkg::IRQ_BIST_FAIL] = (st_reg == chm_pkg::BS_DONE) & run_fail_reg;
  assign istat_next = (istat_reg & ~clr_istat) | ev;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fault_reg       <= 8'h00;
      warn_reg        <= 8'h00;
      istat_reg       <= '0;
      irq             <= 1'b0;
      clk_fault_react <= 1'b0;
    end else if (ce) begin
      fault_reg <= fault_next;
      warn_reg  <= warn_next;
      istat_reg <= istat_next;
      irq       <= |(istat_next & mask_reg[chm_pkg::IRQ_W-1:0]);
      clk_fault_react <= ~bist_busy &
        |(raw.err & chm_pkg::FAULT_MASK & ~(8'h01 << chm_pkg::BIT_CORE));
    end
  end

  // ---------------------------------------------------------------
  // self-test sequencer
  // ---------------------------------------------------------------
  wire auto_trig = (pwrup_active & ~pwrup_d_reg) |
                   (reset_ext_active & ~rext_d_reg);
  wire sw_trig   = wr & hit_bist & pwdata[chm_pkg::BIST_START] & op_state_active;
  wire st_last   = st_cnt_reg == 4'(chm_pkg::BIST_PULSE_CYC - 1);
  wire gap_last  = st_cnt_reg == 4'(chm_pkg::BIST_GAP_CYC - 1);
  wire last_pls  = pulse_reg == 2'(chm_pkg::BIST_PULSES - 1);
  wire resp_ok   = (&mon_err) & ar2_reg;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      chm_pkg::BS_IDLE:  if (auto_trig | sw_trig) st_next = chm_pkg::BS_PULSE;
      chm_pkg::BS_PULSE: if (st_last) st_next = chm_pkg::BS_GAP;
      chm_pkg::BS_GAP:   if (gap_last)
                           st_next = last_pls ? chm_pkg::BS_DONE : chm_pkg::BS_PULSE;
      chm_pkg::BS_DONE:  st_next = chm_pkg::BS_IDLE;
      default:           st_next = chm_pkg::BS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg       <= chm_pkg::BS_IDLE;
      st_cnt_reg   <= 4'h0;
      pulse_reg    <= 2'h0;
      run_fail_reg <= 1'b0;
      tst_reg      <= 1'b0;
      analog_test  <= 1'b0;
      bist_busy    <= 1'b0;
      pwrup_d_reg  <= 1'b0;
      rext_d_reg   <= 1'b0;
    end else if (ce) begin
      pwrup_d_reg <= pwrup_active;
      rext_d_reg  <= reset_ext_active;
      st_reg      <= st_next;
      st_cnt_reg  <= (st_next != st_reg) ? 4'h0 : st_cnt_reg + 4'h1;
      tst_reg     <= st_next == chm_pkg::BS_PULSE;
      analog_test <= st_next == chm_pkg::BS_PULSE;
      bist_busy   <= st_next != chm_pkg::BS_IDLE;
      if (st_reg == chm_pkg::BS_IDLE && st_next == chm_pkg::BS_PULSE) begin
        pulse_reg    <= 2'h0;
        run_fail_reg <= 1'b0;
      end else if (st_reg == chm_pkg::BS_GAP && gap_last) begin
        pulse_reg <= pulse_reg + 2'h1;
      end
      if (st_reg == chm_pkg::BS_PULSE && st_last && !resp_ok)
        run_fail_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst || !ce);

  logic [2:0] pls_seen;
  always_ff @(posedge clk) begin
    if (!nrst)
      pls_seen <= 3'h0;
    else if (ce && st_reg == chm_pkg::BS_IDLE)
      pls_seen <= 3'h0;
    else if (ce && tst_reg && st_cnt_reg == 4'h0)
      pls_seen <= pls_seen + 3'h1;
  end

  sequence s_pulse;
    tst_reg [*8] ##1 !tst_reg;
  endsequence
  sequence s_gap;
    !tst_reg [*8];
  endsequence

  a_timeout_off : assert property (pu_hit |=> off_request && pu_to_reg && fault_reg[0])
    else $error("start-up timeout did not request off");
  a_timer_runs : assert property (pwrup_active && !ak2_reg && !pu_to_reg && !pu_hit
    ##1 ce |-> pu_cnt_reg == $past(pu_cnt_reg) + 32'h1)
    else $error("start-up timer stalled");
  a_trim_gates : assert property (!trim_ok_reg && !tst_reg |-> mon_en == '0)
    else $error("monitor enabled before trim download");
  a_src_select : assert property (ctrl_reg[chm_pkg::CTRL_SRC_SEL] |-> mon_pin[1] == mod_clk)
    else $error("reference is not the modulated clock");
  a_core_no_react : assert property ((raw.err & 8'hFE) == 8'h00 |=> !clk_fault_react)
    else $error("core clock error caused fault reaction");
  a_reset_enables : assert property ($past(!nrst) |-> ctrl_reg == 8'h5B)
    else $error("monitor enables wrong after reset");
  a_auto_start : assert property (st_reg == chm_pkg::BS_IDLE && auto_trig |=> bist_busy)
    else $error("self-test did not start automatically");
  a_pulse_shape : assert property ($rose(tst_reg) |-> s_pulse ##0 s_gap)
    else $error("self-test pulse shape wrong");
  a_two_pulses : assert property ($fell(bist_busy) |-> $past(pls_seen) == 3'h2)
    else $error("self-test did not give two pulses");
  a_flags_sticky : assert property (fault_reg[3] && !clr_fault[3] |=> fault_reg[3])
    else $error("fault flag lost without clear");
  a_err_flagged : assert property (!bist_busy && raw.err[6] |=> fault_reg[6])
    else $error("boost clock error not flagged");
  a_sync_flagged : assert property (!bist_busy && raw.warn[2] |=> warn_reg[2])
    else $error("sync clock warning not flagged");
  a_sw_refused : assert property (wr && hit_bist && !op_state_active && !auto_trig &&
    st_reg == chm_pkg::BS_IDLE |=> !bist_busy)
    else $error("self-test started outside an operating state");
  a_busy_bypass : assert property (bist_busy && !pu_hit && clr_fault == 8'h00 |=>
    fault_reg == $past(fault_reg))
    else $error("self-test reached the fault flags");
  a_mon_forced : assert property (tst_reg |=> &mon_err)
    else $error("test pulse did not trip every monitor");

endmodule : chm_clock_health_monitor

// ===== chm_far_side.sv
// chm_far_side: clock sources and analog supervisor on the monitor's far side
// assumes the bench clock drives it; half periods are counted in clk cycles
`timescale 1ns/1ps
module chm_far_side (
  input  wire logic       clk,      // bench clock
  input  wire logic [7:0] half_nom, // half period of the healthy clocks
  input  wire logic [7:0] half_r1,  // half period of first regulator clock
  input  wire logic       ana_test, // test pulse from the monitor
  output logic            ck_nom,   // healthy clock
  output logic            ck_r1,    // first regulator clock
  output logic            ana_resp  // supervisor response
);
  logic [7:0] cn = 8'h00;
  logic [7:0] c1 = 8'h00;
  initial ck_nom = 1'b0;
  initial ck_r1 = 1'b0;
  always @(posedge clk) begin
    cn <= (cn + 8'h01 >= half_nom) ? 8'h00 : cn + 8'h01;
    c1 <= (c1 + 8'h01 >= half_r1) ? 8'h00 : c1 + 8'h01;
    if (cn + 8'h01 >= half_nom) ck_nom <= ~ck_nom;
    if (c1 + 8'h01 >= half_r1) ck_r1 <= ~ck_r1;
  end
  // a healthy comparator trips on every test pulse
  assign ana_resp = ana_test;
endmodule : chm_far_side

// ===== test_clock_health_monitor.sv
// test_clock_health_monitor: self-checking bench over APB
// assumes chm_pkg compiled first; start-up timeout shortened to 50 cycles
`timescale 1ns/1ps
module test_clock_health_monitor;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, irq, pready, pslverr;
  logic [7:0] paddr = 8'h00, hn = 8'h16, h1 = 8'h16;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic por = 0, tdone = 0, pwr = 0, opst = 0, aok = 1, rext = 0;
  logic cn, c1, atest, aresp, react, off, busy;
  int err_total = 0, checks = 0, cyc = 0, n;
  always #5 clk = ~clk;
  chm_far_side fs (.clk(clk), .half_nom(hn), .half_r1(h1), .ana_test(atest),
    .ck_nom(cn), .ck_r1(c1), .ana_resp(aresp));
  chm_clock_health_monitor #(.PU_TO_CYC(50)) uut (.clk(clk), .nrst(nrst), .ce(1'b1),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_in_clk(cn), .pll_clk(c1),
    .mod_clk(cn), .reg1_clk(c1), .reg2_clk(cn), .boost_clk(cn), .por_released(por),
    .trim_done(tdone), .trim_err(1'b0), .pwrup_active(pwr), .reset_ext_active(rext),
    .op_state_active(opst), .analog_clk_ok(aok), .analog_resp(aresp),
    .off_request(off), .clk_fault_react(react), .analog_test(atest), .bist_busy(busy),
    .irq(irq));
  task automatic give_verdict;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    apb(0, a, 0);
    chk(nm, e, q & m);
  endtask : rd
  task automatic t_reset;
    rd("ctrl", chm_pkg::ADDR_CTRL, 32'hFF, 32'h5B);
    rd("fault", chm_pkg::ADDR_FAULT, 32'hFF, 32'h00);
    apb(0, 8'h18, 0);
    chk("unmapped", 1, pslverr);
  endtask : t_reset
  task automatic t_fault;
    apb(1, chm_pkg::ADDR_CTRL, 32'hDF);
    rd("ctrl rw", chm_pkg::ADDR_CTRL, 32'hFF, 32'hDF);
    por <= 1; tdone <= 1;
    apb(1, chm_pkg::ADDR_IRQ_MASK, 32'h02);
    repeat (3000) @(posedge clk);
    rd("fault idle", chm_pkg::ADDR_FAULT, 32'hFF, 32'h00);
    h1 <= 8'h0A;
    n = 0;
    while (irq !== 1'b1 && n < chm_pkg::DETECT_MAX_CYC) begin @(posedge clk); n++; end
    chk("detect in time", 1, n < chm_pkg::DETECT_MAX_CYC);
    chk("fault reaction", 1, react);
    rd("fault reg1", chm_pkg::ADDR_FAULT, 32'hFF, 32'h08);
    rd("warn reg1", chm_pkg::ADDR_WARN, 32'hFF, 32'h08);
    h1 <= 8'h16;
    repeat (3000) @(posedge clk);
    rd("fault held", chm_pkg::ADDR_FAULT, 32'hFF, 32'h08);
    apb(1, chm_pkg::ADDR_FAULT, 32'hFF);
    apb(1, chm_pkg::ADDR_IRQ_STAT, 32'h1F);
    rd("fault clear", chm_pkg::ADDR_FAULT, 32'hFF, 32'h00);
    chk("irq clear", 0, irq);
  endtask : t_fault
  task automatic t_bist;
    opst <= 1;
    apb(1, chm_pkg::ADDR_BIST, 32'h01);
    n = 0;
    for (int i = 0; i < 60; i++) begin @(posedge clk); n += (atest === 1'b1); end
    chk("pulse cycles", 16, n);
    rd("bist pass", chm_pkg::ADDR_BIST, 32'h06, 32'h00);
    rd("bist done", chm_pkg::ADDR_IRQ_STAT, 32'h08, 32'h08);
    rd("bist no flags", chm_pkg::ADDR_FAULT, 32'hFF, 32'h00);
    opst <= 0;
    apb(1, chm_pkg::ADDR_BIST, 32'h01);
    @(posedge clk);
    chk("start refused", 0, busy);
    rext <= 1;
    repeat (2) @(posedge clk);
    chk("auto start", 1, busy);
    rext <= 0;
    repeat (40) @(posedge clk);
  endtask : t_bist
  task automatic t_timeout;
    aok <= 0; pwr <= 1;
    repeat (120) @(posedge clk);
    chk("off request", 1, off);
    rd("fault core", chm_pkg::ADDR_FAULT, 32'h01, 32'h01);
    rd("timeout flag", chm_pkg::ADDR_BIST, 32'h08, 32'h08);
  endtask : t_timeout
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1;
    t_reset();
    t_fault();
    t_bist();
    t_timeout();
    give_verdict();
  end
endmodule : test_clock_health_monitor
